/* File: spo_defines.svh */
// register offsets, field positions, reset values and constant patterns
`ifndef SPO_DEFINES_SVH
`define SPO_DEFINES_SVH

`define SPO_ADDR_W 8
`define SPO_REG_CTRL 8'h00
`define SPO_REG_STATUS 8'h04
`define SPO_REG_MASK 8'h08
`define SPO_REG_PATH_A 8'h0c
`define SPO_REG_PATH_B 8'h10
`define SPO_REG_PATH_C 8'h14
`define SPO_REG_USER_ADDR 8'h18
`define SPO_REG_USER_DATA 8'h1c
`define SPO_REG_ERR_CNT 8'h20
`define SPO_REG_INFO 8'h24

`define SPO_CTRL_PTYPE_LSB 0
`define SPO_CTRL_INVERT 4
`define SPO_CTRL_RESTART 5
`define SPO_CTRL_DEFAULTS 6
`define SPO_CTRL_CONT_LSB 8
`define SPO_CTRL_TCM_LSB 12
`define SPO_CTRL_MUX_LSB 16

`define SPO_EV_STS_POS 0
`define SPO_EV_STS_NEG 1
`define SPO_EV_VT_POS 2
`define SPO_EV_VT_NEG 3
`define SPO_EV_PAT_ERR 4
`define SPO_EV_W 5

`define SPO_PRBS_SEED 31'h7fffffff
`define SPO_PAT_ALT11 8'h55
`define SPO_PAT_ALT13 8'h88
`define SPO_PAT_ALT17 8'h80
`define SPO_PAT_2IN8 8'h42
`define SPO_USER_WORDS 64
`define SPO_ERR_MAX 16'hffff

`endif

/* File: spo_pkg.sv */
// types shared by the path overhead framer and its pattern generator
package spo_pkg;

   typedef enum logic [3:0] {
      SPO_PT_ALL0 = 4'h0,
      SPO_PT_ALL1 = 4'h1,
      SPO_PT_ALT11 = 4'h2,
      SPO_PT_ALT13 = 4'h3,
      SPO_PT_ALT17 = 4'h4,
      SPO_PT_2IN8 = 4'h5,
      SPO_PT_USER32 = 4'h6,
      SPO_PT_USER2048 = 4'h7,
      SPO_PT_PRBS9 = 4'h8,
      SPO_PT_PRBS11 = 4'h9,
      SPO_PT_PRBS15 = 4'ha,
      SPO_PT_PRBS20 = 4'hb,
      SPO_PT_PRBS23 = 4'hc,
      SPO_PT_PRBS29 = 4'hd,
      SPO_PT_PRBS31 = 4'he
   } spo_ptype_t;

   typedef enum logic [3:0] {
      SPO_SLOT_PAYLOAD = 4'h0,
      SPO_SLOT_J1 = 4'h1,
      SPO_SLOT_B3 = 4'h2,
      SPO_SLOT_C2 = 4'h3,
      SPO_SLOT_G1 = 4'h4,
      SPO_SLOT_F2 = 4'h5,
      SPO_SLOT_H4 = 4'h6,
      SPO_SLOT_Z3 = 4'h7,
      SPO_SLOT_Z4 = 4'h8,
      SPO_SLOT_Z5 = 4'h9,
      SPO_SLOT_V5 = 4'ha,
      SPO_SLOT_J2 = 4'hb,
      SPO_SLOT_Z6 = 4'hc,
      SPO_SLOT_Z7 = 4'hd
   } spo_slot_t;

   typedef enum logic [2:0] {
      SPO_CONT_C4 = 3'h0,
      SPO_CONT_STS3C = 3'h1,
      SPO_CONT_STS1 = 3'h2,
      SPO_CONT_C12 = 3'h3,
      SPO_CONT_C11 = 3'h4
   } spo_cont_t;

   typedef enum logic [1:0] {
      SPO_TCM_OFF = 2'h0,
      SPO_TCM_Z5_STS3C = 2'h1,
      SPO_TCM_Z5_STS1 = 2'h2,
      SPO_TCM_Z6_VT = 2'h3
   } spo_tcm_t;

   typedef enum logic [1:0] {
      SPO_MUX_STS3C = 2'h0,
      SPO_MUX_STS1 = 2'h1,
      SPO_MUX_VT = 2'h2
   } spo_mux_t;

   typedef struct packed {
      logic [30:0] lfsr;
      logic [7:0] ptr;
      logic [7:0] pat_byte;
   } spo_gen_state_t;

   typedef struct packed {
      spo_ptype_t ptype;
      logic invert;
      spo_cont_t container;
      spo_tcm_t tcm;
      spo_mux_t mux_req;
      logic [7:0] j1;
      logic [7:0] c2;
      logic [7:0] f2;
      logic [7:0] h4;
      logic [7:0] z3;
      logic [7:0] z5;
      logic [7:0] j2;
      logic [7:0] z6;
      logic [7:0] g1;
      logic [7:0] z4;
      logic [7:0] v5;
      logic [7:0] z7;
      logic [5:0] user_addr;
      logic [4:0] status;
      logic [4:0] mask;
      logic [15:0] err_cnt;
      logic [7:0] b3_acc;
      logic [7:0] b3;
      logic [1:0] bip2_acc;
      logic [1:0] bip2;
      logic [7:0] tx_byte;
      logic tx_valid;
      logic [31:0] rd_data;
      logic gen_restart;
   } spo_fr_state_t;

endpackage

/* File: spo_pattern_gen.sv */
// payload test pattern generator: fixed, user and pseudo-random bytes
`timescale 1ns/100ps
`include "spo_defines.svh"
module spo_pattern_gen (
   input wire logic core_clk, // line clock
   input wire logic rst_n, // sync reset, active low
   input wire logic restart, // reload seed and pointer
   input wire logic step, // advance one byte
   input wire spo_pkg::spo_ptype_t ptype, // pattern selection
   input wire logic invert, // inverted prbs logic
   input wire logic ram_we, // user word write
   input wire logic [5:0] ram_addr, // user word index
   input wire logic [31:0] ram_data, // user word, first bit in msb
   output logic [7:0] pat_byte // current pattern byte, msb first
);

   logic [31:0] user_ram [0:`SPO_USER_WORDS-1];
   spo_pkg::spo_gen_state_t st;
   spo_pkg::spo_gen_state_t next_st;

   // eight serial prbs steps per byte, first bit lands in msb
   function automatic logic [38:0] prbs_byte(input logic [30:0] s, input logic [4:0] ord, input logic [4:0] tap);
      logic [30:0] v;
      logic [7:0] o;
      logic fb;
      v = s;
      o = 8'h00;
      for (int i = 0; i < 8; i++) begin
         fb = v[ord - 5'h01] ^ v[tap - 5'h01];
         o = {o[6:0], fb};
         v = {v[29:0], fb};
      end
      return {v, o};
   endfunction

   always_ff @(posedge core_clk) begin
      if (ram_we) begin
         user_ram[ram_addr] <= ram_data;
      end
   end

   always_comb begin
      logic [30:0] base_lfsr;
      logic [7:0] base_ptr;
      logic [31:0] word;
      logic [38:0] pr;
      logic [4:0] ord;
      logic [4:0] tap;
      next_st = st;
      base_lfsr = restart ? `SPO_PRBS_SEED : st.lfsr;
      base_ptr = restart ? 8'h00 : st.ptr;
      word = 32'h00000000;
      pr = 39'h0000000000;
      ord = 5'h09;
      tap = 5'h05;
      case (ptype)
         spo_pkg::SPO_PT_PRBS9: begin ord = 5'h09; tap = 5'h05; end
         spo_pkg::SPO_PT_PRBS11: begin ord = 5'h0b; tap = 5'h09; end
         spo_pkg::SPO_PT_PRBS15: begin ord = 5'h0f; tap = 5'h0e; end
         spo_pkg::SPO_PT_PRBS20: begin ord = 5'h14; tap = 5'h03; end
         spo_pkg::SPO_PT_PRBS23: begin ord = 5'h17; tap = 5'h12; end
         spo_pkg::SPO_PT_PRBS29: begin ord = 5'h1d; tap = 5'h1b; end
         spo_pkg::SPO_PT_PRBS31: begin ord = 5'h1f; tap = 5'h1c; end
         default: begin ord = 5'h09; tap = 5'h05; end
      endcase
      if (restart || step) begin
         next_st.ptr = base_ptr;
         next_st.lfsr = base_lfsr;
         case (ptype)
            spo_pkg::SPO_PT_ALL0: next_st.pat_byte = 8'h00;
            spo_pkg::SPO_PT_ALL1: next_st.pat_byte = 8'hff;
            spo_pkg::SPO_PT_ALT11: next_st.pat_byte = `SPO_PAT_ALT11;
            spo_pkg::SPO_PT_ALT13: next_st.pat_byte = `SPO_PAT_ALT13;
            spo_pkg::SPO_PT_ALT17: next_st.pat_byte = `SPO_PAT_ALT17;
            spo_pkg::SPO_PT_2IN8: next_st.pat_byte = `SPO_PAT_2IN8;
            spo_pkg::SPO_PT_USER32: begin
               word = user_ram[0] << {base_ptr[1:0], 3'b000};
               next_st.pat_byte = word[31:24];
               next_st.ptr = {6'h00, base_ptr[1:0] + 2'h1};
            end
            spo_pkg::SPO_PT_USER2048: begin
               word = user_ram[base_ptr[7:2]] << {base_ptr[1:0], 3'b000};
               next_st.pat_byte = word[31:24];
               next_st.ptr = base_ptr + 8'h01;
            end
            default: begin
               pr = prbs_byte(base_lfsr, ord, tap);
               next_st.lfsr = pr[38:8];
               next_st.pat_byte = invert ? ~pr[7:0] : pr[7:0];
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '{lfsr: `SPO_PRBS_SEED, ptr: 8'h00, pat_byte: 8'h00};
      end else begin
         st <= next_st;
      end
   end

   assign pat_byte = st.pat_byte;

endmodule

/* File: spo_path_framer.sv */
// sonet path overhead insertion, payload pattern and receive event status
// What this block does
// - B3 is always computed here; software cannot set it.
// - G1 carries REI count bits 1-4, RDI bit 5, reserved 6-7, spare 8.
// - Z4 carries APS bits 1-4, spare 5-6, data link 7-8.
// - V5 carries BIP-2, REI, RFI, signal label bits 5-7, RDI bit 8.
// - Z7 carries extended label, LO concatenation, APS, reserved, data link.
// - user patterns repeat 32 or 2048 configured bits.
// - PRBS orders 9 to 31, period two to the order minus one.
// - PRBS may be sent normal or bitwise inverted.
// - fixed patterns: all zeros, all ones, alternating 1:1, 1:3, 1:7.
// - two-in-eight pattern 01000010 repeated.
// - standard defaults: inverted PRBS23 for C-4/STS-3c, inverted PRBS15 otherwise.
// - TCM select off/Z5 STS-3c/Z5 STS-1/Z6 VT forces multiplex structure.
// - STS and VT positive and negative justifications reported separately.
// - pattern error flagged whenever a received payload bit mismatches.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "spo_defines.svh"
module spo_path_framer (
   input wire logic core_clk, // line clock, 200 MHz
   input wire logic rst_n, // sync reset, active low
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   output logic irq, // unmasked status pending
   input wire logic tx_slot_valid, // a spe byte is due this cycle
   input wire spo_pkg::spo_slot_t tx_slot, // which spe byte is due
   input wire logic tx_spe_start, // first byte of a new sts spe
   input wire logic tx_vt_start, // first byte of a new vt spe
   output logic [7:0] tx_byte, // generated spe byte
   output logic tx_byte_valid, // tx_byte holds a new byte
   input wire logic rx_valid, // received payload byte valid
   input wire logic [7:0] rx_byte, // received payload byte
   input wire logic rx_sts_pos, // sts positive justification pulse
   input wire logic rx_sts_neg, // sts negative justification pulse
   input wire logic rx_vt_pos, // vt positive justification pulse
   input wire logic rx_vt_neg, // vt negative justification pulse
   output spo_pkg::spo_mux_t mux_struct // multiplex structure in force
);

   spo_pkg::spo_fr_state_t st;
   spo_pkg::spo_fr_state_t next_st;
   logic [7:0] tx_pat;
   logic [7:0] rx_exp;
   logic tx_step;
   logic ram_we;
   spo_pkg::spo_mux_t mux_eff;

   function automatic logic [7:0] xor_bits(input logic [7:0] a, input logic [7:0] b);
      return a ^ b;
   endfunction

   function automatic logic [3:0] popcount8(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'b000, v[i]};
      end
      return n;
   endfunction

   // bip-2: bit 1 over odd positions, bit 2 over even positions
   function automatic logic [1:0] bip2_of(input logic [7:0] v);
      return {v[7] ^ v[5] ^ v[3] ^ v[1], v[6] ^ v[4] ^ v[2] ^ v[0]};
   endfunction

   // tcm selection overrides the requested structure
   function automatic spo_pkg::spo_mux_t mux_of(input spo_pkg::spo_tcm_t t, input spo_pkg::spo_mux_t req);
      case (t)
         spo_pkg::SPO_TCM_Z5_STS3C: return spo_pkg::SPO_MUX_STS3C;
         spo_pkg::SPO_TCM_Z5_STS1: return spo_pkg::SPO_MUX_STS1;
         spo_pkg::SPO_TCM_Z6_VT: return spo_pkg::SPO_MUX_VT;
         default: return req;
      endcase
   endfunction

   assign mux_eff = mux_of(st.tcm, st.mux_req);
   assign tx_step = tx_slot_valid && (tx_slot == spo_pkg::SPO_SLOT_PAYLOAD);
   assign ram_we = reg_wr && (reg_addr == `SPO_REG_USER_DATA);

   spo_pattern_gen u_tx_gen (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .restart(st.gen_restart),
      .step(tx_step),
      .ptype(st.ptype),
      .invert(st.invert),
      .ram_we(ram_we),
      .ram_addr(st.user_addr),
      .ram_data(reg_wdata),
      .pat_byte(tx_pat)
   );

   // the checker copy runs the same sequence, advanced by received bytes
   spo_pattern_gen u_rx_gen (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .restart(st.gen_restart),
      .step(rx_valid),
      .ptype(st.ptype),
      .invert(st.invert),
      .ram_we(ram_we),
      .ram_addr(st.user_addr),
      .ram_data(reg_wdata),
      .pat_byte(rx_exp)
   );

   always_comb begin
      logic [7:0] ob;
      logic [4:0] ev;
      logic [4:0] clr;
      logic [16:0] sum;
      logic [7:0] errs;
      next_st = st;
      ob = 8'h00;
      ev = 5'h00;
      clr = 5'h00;
      sum = 17'h00000;
      errs = 8'h00;
      next_st.gen_restart = 1'b0;
      next_st.tx_valid = tx_slot_valid;

      // spe byte selection
      case (tx_slot)
         spo_pkg::SPO_SLOT_PAYLOAD: ob = tx_pat;
         spo_pkg::SPO_SLOT_J1: ob = st.j1;
         spo_pkg::SPO_SLOT_B3: ob = st.b3;
         spo_pkg::SPO_SLOT_C2: ob = st.c2;
         spo_pkg::SPO_SLOT_G1: ob = {st.g1[7:4], st.g1[3], st.g1[2:1], st.g1[0]};
         spo_pkg::SPO_SLOT_F2: ob = st.f2;
         spo_pkg::SPO_SLOT_H4: ob = st.h4;
         spo_pkg::SPO_SLOT_Z3: ob = st.z3;
         spo_pkg::SPO_SLOT_Z4: ob = {st.z4[7:4], st.z4[3:2], st.z4[1:0]};
         spo_pkg::SPO_SLOT_Z5: ob = st.z5;
         spo_pkg::SPO_SLOT_V5: ob = {st.bip2, st.v5[5], st.v5[4], st.v5[3:1], st.v5[0]};
         spo_pkg::SPO_SLOT_J2: ob = st.j2;
         spo_pkg::SPO_SLOT_Z6: ob = st.z6;
         // ext label, lo concat, aps, reserved, data link
         spo_pkg::SPO_SLOT_Z7: ob = {st.z7[7], st.z7[6], st.z7[5:4], st.z7[3:1], st.z7[0]};
         default: ob = 8'h00;
      endcase
      if (tx_slot_valid) begin
         next_st.tx_byte = ob;
         // parity of previous spe latched at next start
         if (tx_spe_start) begin
            next_st.b3 = st.b3_acc;
            next_st.b3_acc = ob;
         end else begin
            next_st.b3_acc = xor_bits(st.b3_acc, ob);
         end
         if (tx_vt_start) begin
            next_st.bip2 = st.bip2_acc;
            next_st.bip2_acc = bip2_of(ob);
         end else begin
            next_st.bip2_acc = st.bip2_acc ^ bip2_of(ob);
         end
      end

      if (rx_valid) begin
         errs = xor_bits(rx_byte, rx_exp);
         sum = {1'b0, st.err_cnt} + {13'h0000, popcount8(errs)};
         next_st.err_cnt = sum[16] ? `SPO_ERR_MAX : sum[15:0];
         ev[`SPO_EV_PAT_ERR] = |errs;
      end
      ev[`SPO_EV_STS_POS] = rx_sts_pos;
      ev[`SPO_EV_STS_NEG] = rx_sts_neg;
      ev[`SPO_EV_VT_POS] = rx_vt_pos;
      ev[`SPO_EV_VT_NEG] = rx_vt_neg;

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            `SPO_REG_CTRL: begin
               next_st.ptype = spo_pkg::spo_ptype_t'(reg_wdata[`SPO_CTRL_PTYPE_LSB +: 4]);
               next_st.invert = reg_wdata[`SPO_CTRL_INVERT];
               next_st.container = spo_pkg::spo_cont_t'(reg_wdata[`SPO_CTRL_CONT_LSB +: 3]);
               next_st.tcm = spo_pkg::spo_tcm_t'(reg_wdata[`SPO_CTRL_TCM_LSB +: 2]);
               next_st.mux_req = spo_pkg::spo_mux_t'(reg_wdata[`SPO_CTRL_MUX_LSB +: 2]);
               // any pattern change restarts both generators in step
               next_st.gen_restart = 1'b1;
               if (reg_wdata[`SPO_CTRL_DEFAULTS]) begin
                  next_st.invert = 1'b1;
                  if (reg_wdata[`SPO_CTRL_CONT_LSB +: 3] == spo_pkg::SPO_CONT_C4 ||
                      reg_wdata[`SPO_CTRL_CONT_LSB +: 3] == spo_pkg::SPO_CONT_STS3C) begin
                     next_st.ptype = spo_pkg::SPO_PT_PRBS23;
                  end else begin
                     next_st.ptype = spo_pkg::SPO_PT_PRBS15;
                  end
               end
               if (reg_wdata[`SPO_CTRL_RESTART]) begin
                  next_st.err_cnt = 16'h0000;
               end
            end
            `SPO_REG_STATUS: clr = reg_wdata[`SPO_EV_W-1:0];
            `SPO_REG_MASK: next_st.mask = reg_wdata[`SPO_EV_W-1:0];
            `SPO_REG_PATH_A: begin
               next_st.j1 = reg_wdata[7:0];
               next_st.c2 = reg_wdata[15:8];
               next_st.f2 = reg_wdata[23:16];
               next_st.h4 = reg_wdata[31:24];
            end
            `SPO_REG_PATH_B: begin
               next_st.z3 = reg_wdata[7:0];
               next_st.z5 = reg_wdata[15:8];
               next_st.j2 = reg_wdata[23:16];
               next_st.z6 = reg_wdata[31:24];
            end
            `SPO_REG_PATH_C: begin
               next_st.g1 = reg_wdata[7:0];
               next_st.z4 = reg_wdata[15:8];
               next_st.v5 = {2'b00, reg_wdata[21:16]};
               next_st.z7 = reg_wdata[31:24];
            end
            `SPO_REG_USER_ADDR: next_st.user_addr = reg_wdata[5:0];
            `SPO_REG_USER_DATA: next_st.user_addr = st.user_addr + 6'h01;
            default: next_st.user_addr = st.user_addr;
         endcase
      end
      // new events win over a write-one clear in the same cycle
      next_st.status = (st.status & ~clr) | ev;

      // register reads, unmapped reads as zero
      next_st.rd_data = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `SPO_REG_CTRL: begin
               next_st.rd_data[`SPO_CTRL_PTYPE_LSB +: 4] = st.ptype;
               next_st.rd_data[`SPO_CTRL_INVERT] = st.invert;
               next_st.rd_data[`SPO_CTRL_CONT_LSB +: 3] = st.container;
               next_st.rd_data[`SPO_CTRL_TCM_LSB +: 2] = st.tcm;
               next_st.rd_data[`SPO_CTRL_MUX_LSB +: 2] = st.mux_req;
            end
            `SPO_REG_STATUS: next_st.rd_data = {27'h0000000, st.status};
            `SPO_REG_MASK: next_st.rd_data = {27'h0000000, st.mask};
            `SPO_REG_PATH_A: next_st.rd_data = {st.h4, st.f2, st.c2, st.j1};
            `SPO_REG_PATH_B: next_st.rd_data = {st.z6, st.j2, st.z5, st.z3};
            `SPO_REG_PATH_C: next_st.rd_data = {st.z7, st.v5, st.z4, st.g1};
            `SPO_REG_USER_ADDR: next_st.rd_data = {26'h0000000, st.user_addr};
            `SPO_REG_ERR_CNT: next_st.rd_data = {16'h0000, st.err_cnt};
            `SPO_REG_INFO: next_st.rd_data = {14'h0000, mux_eff, 6'h00, st.bip2, st.b3};
            default: next_st.rd_data = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
         st.ptype <= spo_pkg::SPO_PT_PRBS23;
         st.invert <= 1'b1;
         st.gen_restart <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rd_data;
   assign irq = |(st.status & st.mask);
   assign tx_byte = st.tx_byte;
   assign tx_byte_valid = st.tx_valid;
   assign mux_struct = mux_eff;

endmodule

/* File: spo_path_framer_asserts.sv */
// port-level assertions for the path framer
`timescale 1ns/100ps
`include "spo_defines.svh"
module spo_path_framer_asserts (
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset
   input wire logic [7:0] reg_addr, // address
   input wire logic reg_wr, // write
   input wire logic reg_rd, // read
   input wire logic [31:0] reg_rdata, // read data
   input wire logic irq, // interrupt
   input wire logic tx_slot_valid, // slot due
   input wire logic [7:0] tx_byte, // tx byte
   input wire logic tx_byte_valid, // tx strobe
   input wire logic rx_valid, // rx strobe
   input wire logic rx_sts_pos, // event
   input wire logic rx_sts_neg, // event
   input wire logic rx_vt_pos, // event
   input wire logic rx_vt_neg, // event
   input wire spo_pkg::spo_mux_t mux_struct // mux
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_st;
      reg_rd && reg_addr == `SPO_REG_STATUS;
   endsequence
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
   property p_tx_valid;
      tx_slot_valid |=> tx_byte_valid;
   endproperty
   a_tx_valid: assert property (p_tx_valid) else $error("slot gave no byte");
   property p_tx_hold;
      !tx_slot_valid |=> !tx_byte_valid && $stable(tx_byte);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("byte moved without slot");
   property p_irq_rise;
      $rose(irq) |-> $past(rx_valid || reg_wr || rx_sts_pos || rx_sts_neg || rx_vt_pos || rx_vt_neg);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
   property p_irq_fall;
      $fell(irq) |-> $past(reg_wr);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
   property p_mux_hold;
      !$past(reg_wr) |-> $stable(mux_struct) && mux_struct != 2'h3;
   endproperty
   a_mux_hold: assert property (p_mux_hold) else $error("mux changed or illegal");
   property p_ev_sts;
      rx_sts_pos ##1 s_rd_st |=> reg_rdata[`SPO_EV_STS_POS];
   endproperty
   a_ev_sts: assert property (p_ev_sts) else $error("sts event not seen");
   property p_ev_vt;
      rx_vt_neg ##1 s_rd_st |=> reg_rdata[`SPO_EV_VT_NEG];
   endproperty
   a_ev_vt: assert property (p_ev_vt) else $error("vt event not seen");
endmodule
bind spo_path_framer spo_path_framer_asserts i_spo_path_framer_asserts (
   .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .irq, .tx_slot_valid, .tx_byte,
   .tx_byte_valid, .rx_valid, .rx_sts_pos, .rx_sts_neg, .rx_vt_pos, .rx_vt_neg, .mux_struct
);

/* File: spo_far_end.sv */
// far line model: echoes every valid framer byte, optionally corrupted
`timescale 1ns/100ps
module spo_far_end (
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset
   input wire logic loop_en, // echo on
   input wire logic [7:0] flip, // bits to corrupt
   input wire logic [7:0] tx_byte, // from framer
   input wire logic tx_byte_valid, // from framer
   output logic rx_valid, // echo strobe
   output logic [7:0] rx_byte // echo byte
);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         rx_valid <= loop_en && tx_byte_valid;
         // idle line never repeats the last byte
         rx_byte <= (loop_en && tx_byte_valid) ? (tx_byte ^ flip) : ~rx_byte;
      end
   end
endmodule

/* File: spo_path_framer_tb_top.sv */
// self-checking bench: registers, overhead bytes, patterns, events
`timescale 1ns/100ps
`include "spo_defines.svh"
module spo_path_framer_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic tx_slot_valid = 1'b0;
   spo_pkg::spo_slot_t tx_slot = spo_pkg::SPO_SLOT_PAYLOAD;
   logic tx_spe_start = 1'b0;
   logic [3:0] ev = 4'h0;
   logic loop_en = 1'b0;
   logic [7:0] flip = 8'h00;
   logic [31:0] reg_rdata;
   logic irq;
   logic [7:0] tx_byte;
   logic tx_byte_valid;
   logic rx_valid;
   logic [7:0] rx_byte;
   spo_pkg::spo_mux_t mux_struct;
   int mismatches = 0;
   int n_compared = 0;
   int bi[16] = '{0, 0, 0, 1, 8, 2, 3, 4, 9, 5, 0, 6, 7, 11, 0, 0};
   logic [7:0] fx[6] = '{8'h00, 8'hff, 8'h55, 8'h88, 8'h80, 8'h42};
   logic [7:0] q[600];
   logic [7:0] pr[16][16];
   logic [31:0] uw[64];
   logic [95:0] w;
   logic [31:0] d;
   logic [7:0] bx;
   logic [7:0] e;
   logic [7:0] f;
   int m;
   logic ok;
   spo_path_framer i_spo_path_framer (
      .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .tx_slot_valid, .tx_slot,
      .tx_spe_start, .tx_vt_start(tx_spe_start), .tx_byte, .tx_byte_valid, .rx_valid, .rx_byte,
      .rx_sts_pos(ev[0]), .rx_sts_neg(ev[1]), .rx_vt_pos(ev[2]), .rx_vt_neg(ev[3]), .mux_struct
   );
   spo_far_end i_spo_far_end (.core_clk, .rst_n, .loop_en, .flip, .tx_byte, .tx_byte_valid, .rx_valid, .rx_byte);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // also ends any event pulse, so a read can follow it at once
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      ev <= 4'h0;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic send(input logic [3:0] s, input int n, input logic st);
      for (int i = 0; i <= n; i++) begin
         @(posedge core_clk);
         tx_slot_valid <= i < n;
         tx_slot <= spo_pkg::spo_slot_t'(s);
         tx_spe_start <= st && i == 0;
         #1;
         if (i > 0) begin
            q[i - 1] = tx_byte;
            bx ^= tx_byte;
         end
      end
   endtask
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      mismatches++;
      close_out();
   end
   initial begin
      void'($urandom(17434));
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1 chk(32'({irq, tx_byte_valid, mux_struct}), 32'h0);
      for (int a = 1; a < 11; a++) if (a inside {1, 2, 7, 8, 10}) begin
         rd(8'(4 * a));
         chk(d, 32'h0);
      end
      for (int k = 0; k < 3; k++) begin
         w[32 * k +: 32] = $urandom;
         wr(`SPO_REG_PATH_A + 8'(4 * k), w[32 * k +: 32]);
         rd(`SPO_REG_PATH_A + 8'(4 * k));
         chk(d, w[32 * k +: 32] & (k == 2 ? 32'hff3fffff : 32'hffffffff));
      end
      for (int s = 1; s < 14; s++) if (!(s inside {2, 10})) begin
         send(4'(s), 1, 1'b0);
         chk(q[0], w[8 * bi[s] +: 8]);
      end
      bx = 8'h00;
      send(4'h1, 1, 1'b1);
      send(4'h0, 40, 1'b0);
      e = bx;
      send(4'h1, 1, 1'b1);
      send(4'h2, 1, 1'b0);
      chk(q[0], e);
      send(4'ha, 1, 1'b0);
      chk(q[0], {^(e & 8'haa), ^(e & 8'h55), w[85:80]});
      for (int p = 0; p < 6; p++) begin
         wr(`SPO_REG_CTRL, 32'(p) | ($urandom & 32'h10));
         send(4'h0, 4, 1'b0);
         for (int i = 0; i < 4; i++) chk(q[i], fx[p]);
      end
      wr(`SPO_REG_USER_ADDR, 32'h0);
      for (int k = 0; k < 64; k++) begin
         uw[k] = $urandom;
         wr(`SPO_REG_USER_DATA, uw[k]);
      end
      for (int p = 6; p < 8; p++) begin
         wr(`SPO_REG_CTRL, 32'(p));
         send(4'h0, 264, 1'b0);
         for (int i = 0; i < 264; i++) chk(q[i], uw[p == 6 ? 0 : (i / 4) % 64][31 - 8 * (i % 4) -: 8]);
      end
      wr(`SPO_REG_CTRL, 32'h20);
      loop_en <= 1'b1;
      for (int p = 8; p < 15; p++) for (int n = 0; n < 2; n++) begin
         wr(`SPO_REG_CTRL, 32'(p) | 32'(n) << 4);
         send(4'h0, 16, 1'b0);
         ok = 1'b0;
         for (int i = 0; i < 16; i++) begin
            ok |= q[i] !== q[0];
            if (n == 0) pr[p][i] = q[i];
            else chk(q[i], 8'(~pr[p][i]));
         end
         chk(ok, 1'b1);
      end
      wr(`SPO_REG_CTRL, 32'h8);
      send(4'h0, 530, 1'b0);
      for (int i = 0; i < 19; i++) chk(q[i + 511], q[i]);
      rd(`SPO_REG_ERR_CNT);
      chk(d, 32'h0);
      f = 8'($urandom_range(255, 1));
      flip <= f;
      send(4'h0, 1, 1'b0);
      @(posedge core_clk);
      flip <= 8'h00;
      send(4'h0, 3, 1'b0);
      rd(`SPO_REG_ERR_CNT);
      chk(d, 32'($countones(f)));
      rd(`SPO_REG_STATUS);
      chk(d, 32'h10);
      wr(`SPO_REG_MASK, 32'h10);
      #1 chk(irq, 1'b1);
      wr(`SPO_REG_STATUS, 32'h10);
      #1 chk(irq, 1'b0);
      loop_en <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         ev <= 4'(1 << k);
         rd(`SPO_REG_STATUS);
         chk(d, 32'(1 << k));
         chk(irq, 1'b0);
         wr(`SPO_REG_MASK, 32'(1 << k));
         #1 chk(irq, 1'b1);
         wr(`SPO_REG_STATUS, 32'h1f);
         #1 chk(irq, 1'b0);
      end
      for (int t = 0; t < 4; t++) begin
         m = $urandom_range(2, 0);
         wr(`SPO_REG_CTRL, 32'(m) << 16 | 32'(t) << 12);
         #1 chk(32'(mux_struct), 32'(t == 0 ? m : t - 1));
         rd(`SPO_REG_INFO);
         chk(32'(d[17:16]), 32'(t == 0 ? m : t - 1));
         rd(`SPO_REG_CTRL);
         chk(d, 32'(m) << 16 | 32'(t) << 12);
      end
      for (int c = 0; c < 5; c++) begin
         wr(`SPO_REG_CTRL, 32'h40 | 32'(c) << 8);
         send(4'h0, 16, 1'b0);
         for (int i = 0; i < 16; i++) chk(q[i], 8'(~pr[c < 2 ? 12 : 10][i]));
      end
      close_out();
   end
endmodule
